/* pkg/led_pwm_pkg.sv */
package led_pwm_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int NUM_CH = 12;
	localparam int INIT_STEP_US = 1000;
	localparam int INIT_STEP_DEF = INIT_STEP_US * (CLK_HZ / 1_000_000);
	localparam int PWM_TICKS = 256;
	// register byte offsets
	localparam logic [11:0] OFS_CONTROL = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_ENABLE = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam logic [11:0] OFS_FAULTS = 12'h010;
	localparam logic [11:0] OFS_CURRENT = 12'h020;
	localparam logic [11:0] OFS_DUTY_HIGH = 12'h060;
	localparam logic [11:0] OFS_DUTY_LOW = 12'h0a0;
	localparam logic [11:0] CH_SPAN = 12'h030;
	// field positions
	localparam int CTL_POWER_CLR = 0;
	localparam int CTL_RELOAD = 1;
	localparam int CTL_FAULT_CLR = 2;
	localparam int CFG_RANGE_LSB = 0;
	localparam int CFG_FREQ_LSB = 4;
	localparam int CFG_EXP_BIT = 8;
	localparam int CFG_TH_LSB = 12;
	localparam int ST_FLAG_BIT = 0;
	localparam int ST_WARN_BIT = 1;
	localparam int ST_STATE_LSB = 2;
	localparam int FLT_SHORT_LSB = 16;
	localparam logic [3:0] DUTY_LOW_RESET = 4'hf;
	localparam logic [7:0] CNT_LAST = 8'hff;
	// current range multipliers
	localparam logic [9:0] K_RANGE_00 = 10'h040;
	localparam logic [9:0] K_RANGE_01 = 10'h080;
	localparam logic [9:0] K_RANGE_10 = 10'h100;
	localparam logic [9:0] K_RANGE_11 = 10'h200;
	// low supply threshold scale
	localparam int ADC_MV_PER_LSB = 160;
	localparam int TH_MIN_MV = 5000;
	localparam int TH_SPAN_MV = 15000;
	localparam int TH_STEPS = 14;

	typedef enum logic [1:0] {ST_POR, ST_INIT, ST_NORMAL} core_state_t;

	// dimming rate in hz per select code
	function automatic int pwm_freq_hz(input logic [3:0] code);
		unique case (code)
			4'h0: return 200;
			4'h1: return 250;
			4'h2: return 300;
			4'h3: return 400;
			4'h4: return 500;
			4'h5: return 600;
			4'h6: return 800;
			4'h7: return 1000;
			4'h8: return 1200;
			4'h9: return 1600;
			4'ha: return 2000;
			4'hb: return 2500;
			4'hc: return 4000;
			4'hd: return 6000;
			4'he: return 10000;
			4'hf: return 20800;
		endcase
	endfunction

	// pclk cycles per base tick, rounded
	function automatic logic [15:0] pwm_div(input logic [3:0] code);
		int f;
		f = pwm_freq_hz(code);
		return 16'((CLK_HZ + (PWM_TICKS / 2) * f) / (PWM_TICKS * f));
	endfunction

	// code 0 disables; codes 1..15 span 5 V to 20 V
	function automatic logic [7:0] low_th_counts(input logic [3:0] code);
		int mv;
		mv = TH_MIN_MV + (int'(code) - 1) * TH_SPAN_MV / TH_STEPS;
		if (code == 4'h0) begin
			return 8'h00;
		end
		return 8'(mv / ADC_MV_PER_LSB);
	endfunction

	// monotone exponential curve, 8-bit code to 12-bit duty
	function automatic logic [11:0] exp_duty(input logic [7:0] b);
		int v;
		v = ((32 + int'(b[4:0])) << b[7:5]) / 2 - 16;
		return 12'(v);
	endfunction
endpackage

/* logic/led_channel_pwm_and_startup.sv */
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module led_channel_pwm_and_startup
	import led_pwm_pkg::*;
#(
	parameter int INIT_STEP_CYC = INIT_STEP_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic supply_above_uvlo,
	input wire logic ldo_above_uvlo,
	input wire logic [3:0] eep_init_delay,
	input wire logic [1:0] eep_current_range,
	input wire logic [3:0] eep_pwm_freq,
	input wire logic eep_exp_enable,
	input wire logic [3:0] eep_low_supply_th,
	input wire logic [71:0] eep_current_code,
	input wire logic [95:0] eep_duty_high,
	input wire logic [7:0] adc_supply,
	input wire logic adc_supply_valid,
	input wire logic [11:0] open_detect_raw,
	input wire logic [11:0] short_detect_raw,
	output logic [11:0] channel_on,
	output logic [71:0] channel_current_code,
	output logic [1:0] current_range_select,
	output logic [9:0] ref_multiplier,
	output logic err_out,
	output logic err_oe_n
);
	logic [1:0] uv_meta_q;
	logic [1:0] uv_sync_q;
	logic [11:0] open_meta_q;
	logic [11:0] open_sync_q;
	logic [11:0] short_meta_q;
	logic [11:0] short_sync_q;
	logic supply_good;
	core_state_t state_q;
	logic in_por;
	logic setup;
	logic wr_ok;
	logic hit_ctl;
	logic power_flag_clear;
	logic register_reload_strobe;
	logic fault_clear_strobe;
	logic reload_pend_q;
	logic load_defaults;
	logic power_flag_q;
	logic [3:0] init_delay_setting;
	logic [15:0] pre_q;
	logic [3:0] steps_q;
	logic pre_wrap;
	logic init_done;
	logic [3:0] pwm_frequency_select;
	logic exponential_curve_enable;
	logic [3:0] low_supply_threshold;
	logic [11:0] channel_enable;
	logic supply_low_q;
	logic low_supply_warning;
	logic below_now;
	logic [11:0] open_flt_q;
	logic [11:0] short_flt_q;
	logic [15:0] div_cnt_q;
	logic [15:0] div_lim;
	logic base_tick_q;
	logic [5:0] code_w [NUM_CH];
	logic [7:0] dhigh_w [NUM_CH];
	logic [3:0] dlow_w [NUM_CH];
	logic [31:0] rd_d;
	logic err_d;
	logic [3:0] cidx;

	// supply comparators are asynchronous
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_meta_q <= 2'h0;
			uv_sync_q <= 2'h0;
		end else begin
			uv_meta_q <= {ldo_above_uvlo, supply_above_uvlo};
			uv_sync_q <= uv_meta_q;
		end
	end

	// detector pins synchronised per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_meta_q <= 12'h000;
			open_sync_q <= 12'h000;
			short_meta_q <= 12'h000;
			short_sync_q <= 12'h000;
		end else begin
			open_meta_q <= open_detect_raw;
			open_sync_q <= open_meta_q;
			short_meta_q <= short_detect_raw;
			short_sync_q <= short_meta_q;
		end
	end

	assign supply_good = &uv_sync_q;
	assign in_por = (state_q == ST_POR);

	// start-up sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_POR;
		end else if (!supply_good) begin
			state_q <= ST_POR;
		end else begin
			unique case (state_q)
				ST_POR: state_q <= ST_INIT;
				ST_INIT: begin
					if (power_flag_clear || init_done) begin
						state_q <= ST_NORMAL;
					end
				end
				ST_NORMAL: state_q <= ST_NORMAL;
			endcase
		end
	end

	// bus writes are ignored while in reset state
	assign setup = psel && !penable;
	assign wr_ok = psel && penable && pwrite && pready && !in_por;
	assign hit_ctl = wr_ok && (paddr == OFS_CONTROL);
	assign power_flag_clear = hit_ctl && pwdata[CTL_POWER_CLR];
	assign register_reload_strobe = hit_ctl && pwdata[CTL_RELOAD];
	assign fault_clear_strobe = hit_ctl && pwdata[CTL_FAULT_CLR];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_pend_q <= 1'b0;
		end else begin
			reload_pend_q <= register_reload_strobe;
		end
	end

	assign load_defaults = in_por || reload_pend_q;

	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_flag_q <= 1'b1;
		end else if (load_defaults) begin
			power_flag_q <= 1'b1;
		end else if (power_flag_clear) begin
			power_flag_q <= 1'b0;
		end
	end

	// init length is (setting + 1) steps
	assign pre_wrap = (pre_q == 16'(INIT_STEP_CYC - 1));
	assign init_done = pre_wrap && (steps_q == init_delay_setting);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_q <= 16'h0000;
			steps_q <= 4'h0;
		end else if (state_q != ST_INIT) begin
			pre_q <= 16'h0000;
			steps_q <= 4'h0;
		end else if (pre_wrap) begin
			pre_q <= 16'h0000;
			steps_q <= steps_q + 4'h1;
		end else begin
			pre_q <= pre_q + 16'h0001;
		end
	end

	// global configuration; reload beats a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_delay_setting <= 4'h0;
			current_range_select <= 2'h3;
			pwm_frequency_select <= 4'h0;
			exponential_curve_enable <= 1'b0;
			low_supply_threshold <= 4'h0;
			channel_enable <= 12'h000;
		end else if (load_defaults) begin
			init_delay_setting <= eep_init_delay;
			current_range_select <= eep_current_range;
			pwm_frequency_select <= eep_pwm_freq;
			exponential_curve_enable <= eep_exp_enable;
			low_supply_threshold <= eep_low_supply_th;
			channel_enable <= 12'h000;
		end else if (wr_ok && paddr == OFS_CONFIG) begin
			current_range_select <= pwdata[CFG_RANGE_LSB +: 2];
			pwm_frequency_select <= pwdata[CFG_FREQ_LSB +: 4];
			exponential_curve_enable <= pwdata[CFG_EXP_BIT];
			low_supply_threshold <= pwdata[CFG_TH_LSB +: 4];
		end else if (wr_ok && paddr == OFS_ENABLE) begin
			channel_enable <= pwdata[NUM_CH-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_multiplier <= K_RANGE_11;
		end else begin
			unique case (current_range_select)
				2'b00: ref_multiplier <= K_RANGE_00;
				2'b01: ref_multiplier <= K_RANGE_01;
				2'b10: ref_multiplier <= K_RANGE_10;
				2'b11: ref_multiplier <= K_RANGE_11;
			endcase
		end
	end

	assign below_now = adc_supply < low_th_counts(low_supply_threshold);

	// live low-supply state, follows each sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			supply_low_q <= 1'b0;
		end else if (in_por) begin
			supply_low_q <= 1'b0;
		end else if (adc_supply_valid) begin
			supply_low_q <= below_now;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_supply_warning <= 1'b0;
		end else if (in_por) begin
			low_supply_warning <= 1'b0;
		end else if (adc_supply_valid && below_now) begin
			low_supply_warning <= 1'b1;
		end else if (fault_clear_strobe) begin
			low_supply_warning <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_flt_q <= 12'h000;
			short_flt_q <= 12'h000;
		end else if (in_por) begin
			open_flt_q <= 12'h000;
			short_flt_q <= 12'h000;
		end else begin
			open_flt_q <= (fault_clear_strobe ? 12'h000 : open_flt_q)
				| (open_sync_q & channel_enable & {NUM_CH{!supply_low_q}});
			short_flt_q <= (fault_clear_strobe ? 12'h000 : short_flt_q)
				| (short_sync_q & channel_enable & {NUM_CH{!supply_low_q}});
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_oe_n <= 1'b0;
			err_out <= 1'b0;
		end else begin
			err_oe_n <= !(in_por || (|open_flt_q) || (|short_flt_q));
			err_out <= 1'b0;
		end
	end

	assign div_lim = pwm_div(pwm_frequency_select);

	// tick is one pclk wide; limits resolution to 100 ns
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 16'h0000;
			base_tick_q <= 1'b0;
		end else if (div_cnt_q >= div_lim - 16'h0001) begin
			div_cnt_q <= 16'h0000;
			base_tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 16'h0001;
			base_tick_q <= 1'b0;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			localparam logic [11:0] A_CUR = OFS_CURRENT + 12'(4 * i);
			localparam logic [11:0] A_HIGH = OFS_DUTY_HIGH + 12'(4 * i);
			localparam logic [11:0] A_LOW = OFS_DUTY_LOW + 12'(4 * i);
			logic [5:0] code_q;
			logic [7:0] dhigh_q;
			logic [3:0] dlow_q;
			logic [11:0] active_q;
			logic [11:0] run_q;
			logic [7:0] cnt_q;
			logic [3:0] phase_q;
			logic [8:0] on_len;
			logic on_q;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					code_q <= 6'h00;
				end else if (load_defaults) begin
					code_q <= eep_current_code[6*i +: 6];
				end else if (wr_ok && paddr == A_CUR) begin
					code_q <= pwdata[5:0];
				end
			end

			// duty bytes and the value the generator uses
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					dhigh_q <= 8'h00;
					dlow_q <= DUTY_LOW_RESET;
					active_q <= 12'h00f;
				end else if (load_defaults) begin
					dhigh_q <= eep_duty_high[8*i +: 8];
					dlow_q <= DUTY_LOW_RESET;
					active_q <= eep_exp_enable ?
						exp_duty(eep_duty_high[8*i +: 8]) :
						{eep_duty_high[8*i +: 8], DUTY_LOW_RESET};
				end else if (wr_ok && paddr == A_HIGH) begin
					dhigh_q <= pwdata[7:0];
					active_q <= exponential_curve_enable ?
						exp_duty(pwdata[7:0]) : {pwdata[7:0], dlow_q};
				end else if (wr_ok && paddr == A_LOW) begin
					dlow_q <= pwdata[3:0];
				end
			end

			assign on_len = {1'b0, run_q[11:4]}
				+ {8'h00, (phase_q <= run_q[3:0])};

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q <= 8'h00;
					phase_q <= 4'h0;
					run_q <= 12'h00f;
				end else if (in_por) begin
					cnt_q <= 8'h00;
					phase_q <= 4'h0;
					run_q <= {8'h00, DUTY_LOW_RESET};
				end else if (base_tick_q) begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == CNT_LAST) begin
						// new duty only at a period edge
						phase_q <= phase_q + 4'h1;
						run_q <= active_q;
					end
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					on_q <= 1'b0;
				end else begin
					on_q <= !in_por && channel_enable[i]
						&& ({1'b0, cnt_q} < on_len);
				end
			end

			assign channel_on[i] = on_q;
			assign channel_current_code[6*i +: 6] = code_q;
			assign code_w[i] = code_q;
			assign dhigh_w[i] = dhigh_q;
			assign dlow_w[i] = dlow_q;
		end
	endgenerate

	// read decode; unmapped addresses answer with an error
	always_comb begin
		rd_d = 32'h0000_0000;
		err_d = 1'b0;
		cidx = paddr[5:2];
		if (paddr == OFS_CONTROL) begin
			rd_d[CTL_RELOAD] = reload_pend_q;
		end else if (paddr == OFS_CONFIG) begin
			rd_d[CFG_RANGE_LSB +: 2] = current_range_select;
			rd_d[CFG_FREQ_LSB +: 4] = pwm_frequency_select;
			rd_d[CFG_EXP_BIT] = exponential_curve_enable;
			rd_d[CFG_TH_LSB +: 4] = low_supply_threshold;
		end else if (paddr == OFS_ENABLE) begin
			rd_d[NUM_CH-1:0] = channel_enable;
		end else if (paddr == OFS_STATUS) begin
			rd_d[ST_FLAG_BIT] = power_flag_q;
			rd_d[ST_WARN_BIT] = low_supply_warning;
			rd_d[ST_STATE_LSB +: 2] = state_q;
		end else if (paddr == OFS_FAULTS) begin
			rd_d[NUM_CH-1:0] = open_flt_q;
			rd_d[FLT_SHORT_LSB +: NUM_CH] = short_flt_q;
		end else if (paddr[1:0] != 2'b00) begin
			err_d = 1'b1;
		end else if (paddr >= OFS_CURRENT && paddr < OFS_CURRENT + CH_SPAN) begin
			cidx = 4'((paddr - OFS_CURRENT) >> 2);
			rd_d[5:0] = code_w[cidx];
		end else if (paddr >= OFS_DUTY_HIGH
				&& paddr < OFS_DUTY_HIGH + CH_SPAN) begin
			cidx = 4'((paddr - OFS_DUTY_HIGH) >> 2);
			rd_d[7:0] = dhigh_w[cidx];
		end else if (paddr >= OFS_DUTY_LOW
				&& paddr < OFS_DUTY_LOW + CH_SPAN) begin
			cidx = 4'((paddr - OFS_DUTY_LOW) >> 2);
			rd_d[3:0] = dlow_w[cidx];
		end else begin
			err_d = 1'b1;
		end
	end

	// answer captured in setup, shown through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr <= err_d;
			end else if (!(psel && penable)) begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end
endmodule

/* bench/led_pwm_chk.sv */
`timescale 1ns/1ps
module led_pwm_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic supply_above_uvlo,
	input wire logic ldo_above_uvlo,
	input wire logic [11:0] open_detect_raw,
	input wire logic [11:0] short_detect_raw,
	input wire logic [11:0] channel_on,
	input wire logic [71:0] channel_current_code,
	input wire logic [1:0] current_range_select,
	input wire logic [9:0] ref_multiplier,
	input wire logic err_out,
	input wire logic err_oe_n
);
	logic [1:0] up_q;
	logic pwr_ok;
	logic wr_idle;

	// edges since reset release; masks outputs still settling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_q <= 2'd0;
		end else if (up_q != 2'd3) begin
			up_q <= up_q + 2'd1;
		end
	end

	// quiet bus and good supplies: nothing may move the current codes or the range select
	assign pwr_ok = supply_above_uvlo && ldo_above_uvlo;
	assign wr_idle = !(psel && penable && pwrite);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence clean_supply;
		pwr_ok && open_detect_raw == 12'h000 && short_detect_raw == 12'h000;
	endsequence
	sequence supply_back;
		!pwr_ok ##1 clean_supply [*7];
	endsequence

	por_supply_a: assert property (
		(!supply_above_uvlo) [*5] |=> channel_on == 12'h000 && !err_oe_n)
		else $error("outputs active while supply low");
	por_ldo_a: assert property (
		(!ldo_above_uvlo) [*5] |=> channel_on == 12'h000 && !err_oe_n)
		else $error("outputs active while ldo low");
	err_idle_a: assert property (err_out == 1'b0)
		else $error("fault pin driven high");
	init_release_a: assert property (supply_back |-> err_oe_n)
		else $error("fault pulldown kept after supplies good");
	range_map_a: assert property (
		up_q == 2'd3 && $stable(current_range_select)
		|-> ref_multiplier == (10'h040 << current_range_select))
		else $error("multiplier does not match range");
	range_onehot_a: assert property (
		up_q == 2'd3 |-> $onehot(ref_multiplier))
		else $error("multiplier not a legal value");
	code_hold_a: assert property (
		(pwr_ok && wr_idle) [*5] |=> $stable(channel_current_code))
		else $error("current code moved without a write");
	range_hold_a: assert property (
		(pwr_ok && wr_idle) [*5] |=> $stable(current_range_select))
		else $error("range moved without a write");
endmodule

bind led_channel_pwm_and_startup led_pwm_chk i_led_pwm_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.supply_above_uvlo(supply_above_uvlo),
	.ldo_above_uvlo(ldo_above_uvlo),
	.open_detect_raw(open_detect_raw),
	.short_detect_raw(short_detect_raw),
	.channel_on(channel_on),
	.channel_current_code(channel_current_code),
	.current_range_select(current_range_select),
	.ref_multiplier(ref_multiplier),
	.err_out(err_out),
	.err_oe_n(err_oe_n)
);

/* bench/led_string_model.sv */
`timescale 1ns/1ps
module led_string_model (
	input wire logic [11:0] channel_on,
	input wire logic [11:0] open_fault,
	input wire logic [11:0] short_fault,
	input wire logic err_out,
	input wire logic err_oe_n,
	output logic [11:0] open_detect_raw,
	output logic [11:0] short_detect_raw,
	output logic err_line
);
	// a broken string only shows while current is pushed into it
	assign open_detect_raw = open_fault & channel_on;
	assign short_detect_raw = short_fault & channel_on;
	// open-drain line with pull-up: released pin reads high
	assign err_line = err_oe_n ? 1'b1 : err_out;
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
	import led_pwm_pkg::*;
	localparam int DIV = (CLK_HZ + 128 * 20800) / (256 * 20800);
	localparam int DIV_E = (CLK_HZ + 128 * 10000) / (256 * 10000);
	localparam int TH3 = (5000 + 2 * 15000 / 14) / 160;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sup_ok = 1'b0;
	logic ldo_ok = 1'b0;
	logic [3:0] e_th;
	logic [3:0] e_freq;
	logic [1:0] e_rng;
	logic e_exp;
	logic [71:0] e_code;
	logic [95:0] e_duty;
	logic [7:0] adc = 8'h00;
	logic adc_vld = 1'b0;
	logic [11:0] open_f = 12'h000;
	logic [11:0] short_f = 12'h000;
	logic [11:0] open_raw;
	logic [11:0] short_raw;
	logic [11:0] ch_on;
	logic [71:0] code_out;
	logic [1:0] rng_out;
	logic [9:0] kref;
	logic err_out;
	logic err_oe_n;
	logic err_line;
	logic [31:0] cfg_e;
	logic [32:0] exp_q[$];
	logic [32:0] msk_q[$];
	int errors = 0;
	int n_compared = 0;
	int cnt[12];

	always #50 pclk = ~pclk;

	led_channel_pwm_and_startup #(.INIT_STEP_CYC(8)) i_led_channel_pwm_and_startup (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.supply_above_uvlo(sup_ok), .ldo_above_uvlo(ldo_ok),
		.eep_init_delay(4'h2), .eep_current_range(e_rng),
		.eep_pwm_freq(e_freq), .eep_exp_enable(e_exp),
		.eep_low_supply_th(e_th), .eep_current_code(e_code),
		.eep_duty_high(e_duty), .adc_supply(adc), .adc_supply_valid(adc_vld),
		.open_detect_raw(open_raw), .short_detect_raw(short_raw),
		.channel_on(ch_on), .channel_current_code(code_out),
		.current_range_select(rng_out), .ref_multiplier(kref),
		.err_out(err_out), .err_oe_n(err_oe_n));

	led_string_model i_led_string_model (
		.channel_on(ch_on), .open_fault(open_f), .short_fault(short_f),
		.err_out(err_out), .err_oe_n(err_oe_n),
		.open_detect_raw(open_raw), .short_detect_raw(short_raw),
		.err_line(err_line));

	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		n_compared++;
		if (seen !== want) begin
			errors++;
			$display("ERROR %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	// note the expectation first; the monitor compares it
	task automatic rd(input logic [11:0] a, input logic [31:0] want,
		input logic [31:0] m, input logic err = 1'b0);
		exp_q.push_back({err, want & m});
		msk_q.push_back({1'b1, m});
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic st(input logic f, input logic w, input logic [1:0] s);
		rd(OFS_STATUS, {28'h0, s, w, f}, 32'h0000_000f);
	endtask

	task automatic pulse(input logic [7:0] v);
		@(posedge pclk);
		adc <= v;
		adc_vld <= 1'b1;
		@(posedge pclk);
		adc_vld <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask

	// n must span whole periods, else dithering does not average out
	task automatic measure(input int n);
		foreach (cnt[i]) cnt[i] = 0;
		repeat (n) begin
			@(posedge pclk);
			for (int i = 0; i < 12; i++) cnt[i] += int'(ch_on[i]);
		end
	endtask

	task automatic tend(input string s);
		$display("test %s done", s);
	endtask

	// read results; the tag of each sits at its rd call
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
		end
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		errors++;
		test_done();
	end

	initial begin
		logic [5:0] c;
		void'($urandom(93));
		e_th = 4'($urandom);
		e_freq = 4'($urandom);
		e_rng = 2'($urandom);
		e_exp = 1'($urandom);
		e_code = 72'({$urandom, $urandom, $urandom});
		e_duty = {$urandom, $urandom, $urandom};
		cfg_e = {16'h0, e_th, 3'b000, e_exp, e_freq, 2'b00, e_rng};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		check({32'h0, err_line}, 33'h0);
		check({21'h0, ch_on}, 33'h0);
		st(1'b1, 1'b0, 2'd0);
		rd(OFS_CONFIG, cfg_e, 32'h0000_f1f3);
		rd(OFS_DUTY_LOW + 12'h010, 32'hf, 32'hf);
		wr(OFS_ENABLE, 32'h0000_0fff);
		rd(OFS_ENABLE, 32'h0, 32'h0000_0fff);
		for (int i = 0; i < 12; i++) begin
			rd(OFS_CURRENT + 12'(4 * i), {26'h0, e_code[6*i +: 6]}, 32'h3f);
		end
		tend("por");
		sup_ok <= 1'b1;
		ldo_ok <= 1'b1;
		repeat (10) @(posedge pclk);
		check({32'h0, err_line}, 33'h1);
		st(1'b1, 1'b0, 2'd1);
		repeat (8) @(posedge pclk);
		st(1'b1, 1'b0, 2'd1);
		repeat (12) @(posedge pclk);
		st(1'b1, 1'b0, 2'd2);
		tend("init");
		// an ldo dip sends the core back through reset
		ldo_ok <= 1'b0;
		repeat (6) @(posedge pclk);
		check({32'h0, err_line}, 33'h0);
		st(1'b1, 1'b0, 2'd0);
		ldo_ok <= 1'b1;
		repeat (10) @(posedge pclk);
		st(1'b1, 1'b0, 2'd1);
		wr(OFS_CONTROL, 32'h1);
		st(1'b0, 1'b0, 2'd2);
		tend("clear");
		for (int r = 0; r < 4; r++) begin
			wr(OFS_CONFIG, 32'h0000_30f0 | 32'(r));
			repeat (2) @(posedge pclk);
			check({31'h0, rng_out}, 33'(r));
			check({23'h0, kref}, 33'(64 << r));
		end
		for (int i = 0; i < 12; i++) begin
			c = 6'($urandom);
			wr(OFS_CURRENT + 12'(4 * i), {26'h0, c});
			repeat (2) @(posedge pclk);
			check({27'h0, code_out[6*i +: 6]}, {27'h0, c});
		end
		tend("current");
		wr(OFS_ENABLE, 32'h7);
		wr(OFS_DUTY_LOW, 32'h3);
		wr(OFS_DUTY_HIGH, 32'h40);
		wr(OFS_DUTY_LOW + 12'h004, 32'hf);
		wr(OFS_DUTY_HIGH + 12'h004, 32'h20);
		wr(OFS_DUTY_HIGH + 12'h00c, 32'h80);
		// low nibble alone must not reach the generator
		wr(OFS_DUTY_LOW, 32'h9);
		wr(OFS_CONFIG, 32'h0000_31f3);
		wr(OFS_DUTY_HIGH + 12'h008, 32'h65);
		repeat (1100) @(posedge pclk);
		measure(8192);
		check(33'(cnt[0]), 33'(DIV * (16 * 64 + 3 + 1)));
		check(33'(cnt[1]), 33'(DIV * (16 * 32 + 15 + 1)));
		check(33'(cnt[2]), 33'(DIV * ((37 << 3) / 2 - 16 + 1)));
		check(33'(cnt[3]), 33'd0);
		// slower rate: ch1 has no dither, so one period is enough
		wr(OFS_CONFIG, 32'h0000_31e3);
		repeat (1100) @(posedge pclk);
		measure(1024);
		check(33'(cnt[1]), 33'(DIV_E * (32 + 1)));
		wr(OFS_CONFIG, 32'h0000_31f3);
		tend("pwm");
		pulse(8'(TH3));
		st(1'b0, 1'b0, 2'd2);
		pulse(8'(TH3 - 1));
		st(1'b0, 1'b1, 2'd2);
		open_f <= 12'h001;
		short_f <= 12'h002;
		repeat (600) @(posedge pclk);
		rd(OFS_FAULTS, 32'h0, 32'h0fff_0fff);
		check({32'h0, err_line}, 33'h1);
		pulse(8'd200);
		repeat (600) @(posedge pclk);
		st(1'b0, 1'b1, 2'd2);
		rd(OFS_FAULTS, 32'h0002_0001, 32'h0fff_0fff);
		check({32'h0, err_line}, 33'h0);
		open_f <= 12'h000;
		short_f <= 12'h000;
		repeat (4) @(posedge pclk);
		wr(OFS_CONTROL, 32'h4);
		st(1'b0, 1'b0, 2'd2);
		rd(OFS_FAULTS, 32'h0, 32'h0fff_0fff);
		tend("supply");
		wr(OFS_CONTROL, 32'h2);
		repeat (2) @(posedge pclk);
		rd(OFS_CONTROL, 32'h0, 32'h2);
		rd(OFS_CONFIG, cfg_e, 32'h0000_f1f3);
		rd(OFS_ENABLE, 32'h0, 32'h0000_0fff);
		st(1'b1, 1'b0, 2'd2);
		rd(OFS_DUTY_LOW, 32'hf, 32'hf);
		tend("reload");
		rd(12'h400, 32'h0, 32'hffff_ffff, 1'b1);
		rd(12'h022, 32'h0, 32'hffff_ffff, 1'b1);
		tend("bus");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check({32'h0, err_line}, 33'h0);
		check({21'h0, ch_on}, 33'h0);
		presetn <= 1'b1;
		rd(OFS_STATUS, 32'h1, 32'h1);
		tend("reset");
		test_done();
	end
endmodule
